/* hw/eesl_pkg.sv */
// Shared constants and types of the two-wire serial memory slave.
// Assumes a 10 MHz system clock that samples the bus pins as plain inputs.
package eesl_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Timing.

    // The system clock rate, in kHz.
    localparam int unsigned CLK_FREQ_KHZ = 10000;
    // Longest internal_program_time, in ms.
    localparam int unsigned PROG_TIME_MS = 5;
    // Cycles of the self-timed program; the longest time is a whole number of cycles.
    localparam int unsigned PROG_CYCLES  = PROG_TIME_MS * CLK_FREQ_KHZ;

    ////////////////////////////////////////////////////////////////////////////
    // Array and word layout.

    localparam int unsigned ADDR_W     = 15;
    localparam int unsigned COL_W      = 6;
    localparam int unsigned ROW_W      = ADDR_W - COL_W;
    localparam int unsigned PAGE_BYTES = 64;
    localparam int unsigned MEM_BYTES  = 32768;
    localparam int unsigned FIFO_DEPTH = 4;
    localparam int unsigned PROG_CNT_W = 16;

    // Fixed device-type pattern in the upper nibble of the device address word.
    localparam logic [3:0] DEV_TYPE    = 4'ha;
    // Bit counter value after the eighth data bit, and during the ninth clock.
    localparam logic [3:0] BIT_LAST    = 4'h7;
    localparam logic [3:0] BIT_ACK     = 4'h8;
    // Reset value of the pin samplers: clock and data idle high.
    localparam logic [5:0] PINS_RESET  = 6'h30;

    ////////////////////////////////////////////////////////////////////////////
    // Types.

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_DEV  = 3'h1,
        ST_AHI  = 3'h2,
        ST_ALO  = 3'h3,
        ST_WDAT = 3'h4,
        ST_RDAT = 3'h5
    } eesl_state_t;

    // One received write byte with its column inside the page.
    typedef struct packed {
        logic [5:0] col;
        logic [7:0] data;
    } eesl_wr_item_t;

    // Pins sampled from outside the clock domain.
    typedef struct packed {
        logic       scl;
        logic       sda;
        logic       wp;
        logic [2:0] straps;
    } eesl_pins_t;

endpackage

/* hw/eesl_slave.sv */
// Two-wire serial memory slave: bus protocol engine, write FIFO, page buffer,
// self-timed program cycle and the 32K x 8 array.
// Assumes an external pull-up on the data line and a bus clock far slower than i_clk.
//
// How it works
// - Data changes only while the clock is low; changes while high are start or stop.
// - Data falling while clock is high is a start; a start precedes every command.
// - Data rising while clock is high is a stop; after a read it returns to standby.
// - Words are eight bits; the memory pulls data low in the ninth clock to acknowledge.
// - Standby at power-up and after a stop once internal work is done.
// - Start, nine clocks, start, stop recovers the interface for a new transfer.
// - The device address word follows the start; its upper nibble is the device type.
// - The next three bits must equal the three chip select straps.
// - The eighth bit selects direction: high reads, low writes.
// - A match is acknowledged low; a mismatch is not acknowledged and goes to standby.
// - While write protect is high no new write starts; a program cycle already running still finishes.
// - Byte write: device address, two address bytes, one data byte, each acknowledged, stop.
// - After the stop a self-timed write of at most 5 ms runs, ignoring inputs.
// - The write interval runs from the valid stop to the end of programming.
// - Page write: up to 63 more data bytes, each acknowledged, 64-byte pages, then stop.
// - Only the six low address bits increment in a page write, wrapping in the page.
// - While writing internally a device address gets no acknowledge; afterwards it does.
// - The address counter holds last address plus one; reads wrap at the array end.
// - Current-address read sends the byte at the counter; controller nacks and stops.
// - Random read: dummy write loads the address, repeated start, read, nack, stop.
// - Sequential read continues while the controller acknowledges, wrapping at the array end.
// - Incoming data is sampled on the clock rise, outgoing data changes after the fall.
// - The array is 512 pages of 64 bytes, reached by a 15-bit word address.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Small synchronous FIFO with valid and ready on both sides.
module eesl_fifo #(
    parameter int unsigned WIDTH = 14,
    parameter int unsigned DEPTH = 4
) (
    input  wire logic             i_clk,
    input  wire logic             i_reset_n,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data
);
    localparam int unsigned PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PTR_W:0]   wr_ptr;
    logic [PTR_W:0]   rd_ptr;
    logic [PTR_W:0]   next_wr_ptr;
    logic [PTR_W:0]   next_rd_ptr;
    logic             push;
    logic             pop;

    // Full when the pointers differ only in their wrap bit, empty when equal.
    assign o_in_ready  = !((wr_ptr[PTR_W] != rd_ptr[PTR_W]) &&
                           (wr_ptr[PTR_W-1:0] == rd_ptr[PTR_W-1:0]));
    assign o_out_valid = (wr_ptr != rd_ptr);
    assign o_out_data  = store[rd_ptr[PTR_W-1:0]];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    // Pointer update.
    always_comb begin
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    end

    // Pointer registers.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    // Storage needs no reset; only words below the write pointer are read.
    always_ff @(posedge i_clk) begin
        if (push) begin
            store[wr_ptr[PTR_W-1:0]] <= i_in_data;
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Protocol engine and memory.
module eesl_slave #(
    parameter int unsigned PROG_CYCLES = eesl_pkg::PROG_CYCLES
) (
    input  wire logic       i_clk,
    input  wire logic       i_reset_n,
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    output logic            o_sda_out,
    output logic            o_sda_oe,
    input  wire logic       i_wp,
    input  wire logic [2:0] i_chip_select_straps,
    output logic            o_standby
);
    localparam logic [eesl_pkg::PROG_CNT_W-1:0] PROG_LAST =
        eesl_pkg::PROG_CNT_W'(PROG_CYCLES - 1);

    eesl_pkg::eesl_pins_t          pins_s1;
    eesl_pkg::eesl_pins_t          pins_s2;
    eesl_pkg::eesl_pins_t          pins_d;
    logic                          scl_rise;
    logic                          scl_fall;
    logic                          start_det;
    logic                          stop_det;

    eesl_pkg::eesl_state_t         st;
    eesl_pkg::eesl_state_t         pend;
    logic [3:0]                    bit_cnt;
    logic [7:0]                    shreg;
    logic [7:0]                    out_sh;
    logic                          sda_oe;
    logic [eesl_pkg::ADDR_W-1:0]   addr_cnt;
    logic [6:0]                    addr_hi;
    logic                          mack;
    eesl_pkg::eesl_state_t         next_st;
    eesl_pkg::eesl_state_t         next_pend;
    eesl_pkg::eesl_state_t         target;
    logic [3:0]                    next_bit_cnt;
    logic [7:0]                    next_shreg;
    logic [7:0]                    next_out_sh;
    logic                          next_sda_oe;
    logic [eesl_pkg::ADDR_W-1:0]   next_addr_cnt;
    logic [6:0]                    next_addr_hi;
    logic                          next_mack;
    logic                          addr_load;

    logic                          push_valid;
    logic                          push_ready;
    eesl_pkg::eesl_wr_item_t       push_item;
    logic                          pop_valid;
    logic                          pop_ready;
    eesl_pkg::eesl_wr_item_t       pop_item;

    logic                          busy;
    logic [eesl_pkg::PROG_CNT_W-1:0] prog_cnt;
    logic [6:0]                    commit_idx;
    logic [eesl_pkg::ROW_W-1:0]    page_row;
    logic [eesl_pkg::PAGE_BYTES-1:0] page_mask;
    logic                          next_busy;
    logic [eesl_pkg::PROG_CNT_W-1:0] next_prog_cnt;
    logic [6:0]                    next_commit_idx;
    logic [eesl_pkg::ROW_W-1:0]    next_page_row;
    logic [eesl_pkg::PAGE_BYTES-1:0] next_page_mask;
    logic                          commit_we;

    logic [7:0]                    mem [eesl_pkg::MEM_BYTES];
    logic [7:0]                    page_buf [eesl_pkg::PAGE_BYTES];
    logic [7:0]                    rd_q;

    ////////////////////////////////////////////////////////////////////////////
    // Pin sampling and bus condition detection.

    // Two flip-flops per pin, then one more stage for the edge detectors.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pins_s1 <= eesl_pkg::PINS_RESET;
            pins_s2 <= eesl_pkg::PINS_RESET;
            pins_d  <= eesl_pkg::PINS_RESET;
        end else begin
            pins_s1 <= {i_scl, i_sda, i_wp, i_chip_select_straps};
            pins_s2 <= pins_s1;
            pins_d  <= pins_s2;
        end
    end

    // Clock edges, and data edges while the clock stays high.
    assign scl_rise  = pins_s2.scl && !pins_d.scl;
    assign scl_fall  = !pins_s2.scl && pins_d.scl;
    assign start_det = pins_s2.scl && pins_d.scl && pins_d.sda && !pins_s2.sda;
    assign stop_det  = pins_s2.scl && pins_d.scl && !pins_d.sda && pins_s2.sda;

    ////////////////////////////////////////////////////////////////////////////
    // Protocol engine.

    // Byte framing, acknowledge generation, address handling and read shifting.
    always_comb begin
        next_st       = st;
        next_pend     = pend;
        next_bit_cnt  = bit_cnt;
        next_shreg    = shreg;
        next_out_sh   = out_sh;
        next_sda_oe   = sda_oe;
        next_addr_cnt = addr_cnt;
        next_addr_hi  = addr_hi;
        next_mack     = mack;
        addr_load     = 1'b0;
        push_valid    = 1'b0;
        target        = pend;
        if (stop_det) begin
            // A stop ends every sequence and leaves the line released.
            next_st      = eesl_pkg::ST_IDLE;
            next_bit_cnt = '0;
            next_sda_oe  = 1'b0;
        end else if (start_det) begin
            // A start aborts the word; the clock fall after it wraps the count to zero.
            next_st      = eesl_pkg::ST_DEV;
            next_bit_cnt = '1;
            next_sda_oe  = 1'b0;
        end else if (st != eesl_pkg::ST_IDLE) begin
            if (scl_rise) begin
                if (bit_cnt == eesl_pkg::BIT_ACK) begin
                    next_mack = pins_s2.sda;
                end else begin
                    next_shreg = {shreg[6:0], pins_s2.sda};
                end
            end else if (scl_fall) begin
                if (bit_cnt == eesl_pkg::BIT_LAST) begin
                    // Eighth bit done: decide the acknowledge for the ninth clock.
                    next_bit_cnt = eesl_pkg::BIT_ACK;
                    next_sda_oe  = 1'b0;
                    unique case (st)
                        eesl_pkg::ST_DEV: begin
                            if ((shreg[7:4] == eesl_pkg::DEV_TYPE) &&
                                (shreg[3:1] == pins_s2.straps) && !busy) begin
                                next_sda_oe = 1'b1;
                                next_pend   = shreg[0] ? eesl_pkg::ST_RDAT :
                                                         eesl_pkg::ST_AHI;
                            end else begin
                                next_pend = eesl_pkg::ST_IDLE;
                            end
                        end
                        eesl_pkg::ST_AHI: begin
                            next_addr_hi = shreg[6:0];
                            next_sda_oe  = 1'b1;
                            next_pend    = eesl_pkg::ST_ALO;
                        end
                        eesl_pkg::ST_ALO: begin
                            next_addr_cnt = {addr_hi, shreg};
                            addr_load     = 1'b1;
                            next_sda_oe   = 1'b1;
                            next_pend     = eesl_pkg::ST_WDAT;
                        end
                        eesl_pkg::ST_WDAT: begin
                            if (push_ready) begin
                                // Protected bytes are acknowledged but dropped.
                                push_valid    = !pins_s2.wp;
                                next_sda_oe   = 1'b1;
                                next_addr_cnt = {addr_cnt[14:6],
                                                 addr_cnt[5:0] + 6'h01};
                            end else begin
                                next_pend = eesl_pkg::ST_IDLE;
                            end
                        end
                        eesl_pkg::ST_RDAT: begin
                            next_pend = eesl_pkg::ST_RDAT;
                        end
                        default: begin
                            next_pend = eesl_pkg::ST_IDLE;
                        end
                    endcase
                end else if (bit_cnt == eesl_pkg::BIT_ACK) begin
                    // Ninth clock over: release and enter the next word.
                    next_bit_cnt = '0;
                    next_sda_oe  = 1'b0;
                    if (st == eesl_pkg::ST_RDAT) begin
                        target = mack ? eesl_pkg::ST_IDLE : eesl_pkg::ST_RDAT;
                    end
                    next_st = target;
                    if (target == eesl_pkg::ST_RDAT) begin
                        next_out_sh   = rd_q;
                        next_sda_oe   = !rd_q[7];
                        next_addr_cnt = addr_cnt + 15'h0001;
                    end
                end else begin
                    next_bit_cnt = bit_cnt + 4'h1;
                    if (st == eesl_pkg::ST_RDAT) begin
                        next_out_sh = {out_sh[6:0], 1'b0};
                        next_sda_oe = !out_sh[6];
                    end
                end
            end
        end
    end

    // Protocol registers; standby after reset.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st       <= eesl_pkg::ST_IDLE;
            pend     <= eesl_pkg::ST_IDLE;
            bit_cnt  <= '0;
            shreg    <= '0;
            out_sh   <= '0;
            sda_oe   <= 1'b0;
            addr_cnt <= '0;
            addr_hi  <= '0;
            mack     <= 1'b1;
        end else begin
            st       <= next_st;
            pend     <= next_pend;
            bit_cnt  <= next_bit_cnt;
            shreg    <= next_shreg;
            out_sh   <= next_out_sh;
            sda_oe   <= next_sda_oe;
            addr_cnt <= next_addr_cnt;
            addr_hi  <= next_addr_hi;
            mack     <= next_mack;
        end
    end

    // The data pin is open drain: the level driven is always low.
    assign o_sda_out = 1'b0;
    assign o_sda_oe  = sda_oe;
    assign o_standby = (st == eesl_pkg::ST_IDLE) && !busy;
    assign push_item = '{col: addr_cnt[5:0], data: shreg};

    ////////////////////////////////////////////////////////////////////////////
    // Write path: FIFO, page buffer and self-timed program cycle.

    eesl_fifo #(
        .WIDTH ($bits(eesl_pkg::eesl_wr_item_t)),
        .DEPTH (eesl_pkg::FIFO_DEPTH)
    ) u_wr_fifo (
        .i_clk       (i_clk),
        .i_reset_n   (i_reset_n),
        .i_in_valid  (push_valid),
        .o_in_ready  (push_ready),
        .i_in_data   (push_item),
        .o_out_valid (pop_valid),
        .i_out_ready (pop_ready),
        .o_out_data  (pop_item)
    );

    // The page buffer is filled only while no program cycle owns it.
    assign pop_ready = !busy;
    assign commit_we = busy && !commit_idx[6] && page_mask[commit_idx[5:0]];

    // Page bookkeeping and program timing.
    always_comb begin
        next_busy       = busy;
        next_prog_cnt   = prog_cnt;
        next_commit_idx = commit_idx;
        next_page_row   = page_row;
        next_page_mask  = page_mask;
        if (addr_load) begin
            next_page_row  = next_addr_cnt[14:6];
            next_page_mask = '0;
        end else if (pop_valid && pop_ready) begin
            next_page_mask[pop_item.col] = 1'b1;
        end
        if (busy) begin
            // Copy marked bytes early, then hold off until the full interval ends.
            if (!commit_idx[6]) begin
                next_commit_idx = commit_idx + 7'h01;
            end
            if (prog_cnt == '0) begin
                next_busy      = 1'b0;
                next_page_mask = '0;
            end else begin
                next_prog_cnt = prog_cnt - 1'b1;
            end
        end else if (stop_det && (|page_mask) && !pins_s2.wp) begin
            next_busy       = 1'b1;
            next_prog_cnt   = PROG_LAST;
            next_commit_idx = '0;
        end else if (stop_det && pins_s2.wp) begin
            next_page_mask = '0;
        end
    end

    // Program cycle registers.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            busy       <= 1'b0;
            prog_cnt   <= '0;
            commit_idx <= '0;
            page_row   <= '0;
            page_mask  <= '0;
        end else begin
            busy       <= next_busy;
            prog_cnt   <= next_prog_cnt;
            commit_idx <= next_commit_idx;
            page_row   <= next_page_row;
            page_mask  <= next_page_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Storage.

    // Page buffer fill, array program and registered array read.
    always_ff @(posedge i_clk) begin
        if (pop_valid && pop_ready) begin
            page_buf[pop_item.col] <= pop_item.data;
        end
        if (commit_we) begin
            mem[{page_row, commit_idx[5:0]}] <= page_buf[commit_idx[5:0]];
        end
        rd_q <= mem[addr_cnt];
    end
endmodule

/* verif/eesl_monitor.sv */
// Checker of the two-wire memory slave, watching only its top ports.
// Assumes the bench bus clock runs at 8 system cycles a bit.
`timescale 1ns/100ps
module eesl_monitor #(
    parameter int unsigned PROG_CYCLES = 200
) (
    input wire logic       i_clk,
    input wire logic       i_reset_n,
    input wire logic       i_scl,
    input wire logic       i_sda,
    input wire logic       o_sda_out,
    input wire logic       o_sda_oe,
    input wire logic       i_wp,
    input wire logic [2:0] i_chip_select_straps,
    input wire logic       o_standby
);
    localparam int LIM = PROG_CYCLES + 8;
    logic [15:0] busy_cnt;
    logic [15:0] next_busy_cnt;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    ////////////////////////////////////////////////////////////////////////////
    // Counts busy cycles while the bus sits idle, to bound the program time.
    always_comb begin
        next_busy_cnt = (!o_standby && i_scl && i_sda) ? busy_cnt + 16'h0001 : 16'h0000;
    end
    // Registers the busy count.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            busy_cnt <= 16'h0000;
        end else begin
            busy_cnt <= next_busy_cnt;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Protocol relations.
    a_reset_quiet: assert property ($rose(i_reset_n) |-> !o_sda_oe && o_standby)
        else $error("bus not quiet after reset");
    a_never_high: assert property (o_sda_out == 1'h0)
        else $error("data pin driven high");
    a_change_clk_low: assert property ($changed(o_sda_oe) |-> !i_scl)
        else $error("data changed with clock high");
    a_ack_whole_bit: assert property ($rose(o_sda_oe) |-> o_sda_oe [*8])
        else $error("pull-down shorter than a bit");
    a_idle_quiet: assert property (o_standby |-> !o_sda_oe)
        else $error("driving while in standby");
    a_start_wakes: assert property (o_standby && i_scl && $fell(i_sda)
        |-> ##[1:5] !o_standby)
        else $error("start not taken");
    a_wp_no_prog: assert property (i_wp && $past(i_wp, 4)
        && i_scl && $rose(i_sda) |-> ##[1:5] o_standby)
        else $error("program ran under write protect");
    a_prog_bound: assert property (busy_cnt <= LIM)
        else $error("program cycle too long");
endmodule

/* verif/eesl_ctrl_model.sv */
// Bus controller model: makes the bus clock and pulls the data line low.
// Assumes a pull-up on the data line; the clock stands high between frames.
`timescale 1ns/100ps
module eesl_ctrl_model (
    input  wire logic i_clk,
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda_low
);
    // Idle bus at time zero.
    initial begin
        o_scl = 1'h1;
        o_sda_low = 1'h0;
    end
    // Waits n falling edges of the system clock.
    task automatic hold(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    // Sets both lines, then holds them a quarter bit.
    task automatic step(input logic s, input logic l);
        o_scl = s;
        o_sda_low = l;
        hold(2);
    endtask
    // Data falls while the clock is high; also a repeated start.
    task automatic start();
        step(o_scl, 1'h0);
        step(1'h1, 1'h0);
        step(1'h1, 1'h1);
        step(1'h0, 1'h1);
    endtask
    // Data rises while the clock is high.
    task automatic stop();
        step(1'h0, 1'h1);
        step(1'h1, 1'h1);
        step(1'h1, 1'h0);
    endtask
    // One bit: data set while the clock is low, sampled mid high.
    task automatic bitx(input logic v, output logic s);
        step(1'h0, !v);
        step(1'h1, !v);
        s = i_sda;
        step(1'h1, !v);
        step(1'h0, !v);
    endtask
    // Sends a byte MSB first, then releases for the acknowledge.
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bitx(b[i], s);
        bitx(1'h1, s);
        ack = !s;
    endtask
    // Takes a byte, then acknowledges or withholds it.
    task automatic rbyte(input logic nack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) bitx(1'h1, b[i]);
        bitx(nack, s);
    endtask
endmodule

/* verif/eesl_slave_test.sv */
// Self-checking bench of the two-wire memory slave.
// Assumes the package, design, monitor and controller model are compiled first.
`timescale 1ns/100ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module eesl_slave_test;
    localparam logic [7:0] DW = 8'haa;  // Device word, straps 101, write.
    localparam logic [7:0] DR = 8'hab;  // Device word, straps 101, read.
    logic i_clk;
    logic i_reset_n;
    logic i_wp;
    logic scl;
    logic low;
    logic oe;
    logic standby;
    wire  sda = !(low || oe);  // Wired bus level with its pull-up.
    int   n_errors;
    int   comparisons;
    eesl_slave #(.PROG_CYCLES(200)) u_eesl_slave (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_scl(scl), .i_sda(sda), .o_sda_out(), .o_sda_oe(oe), .i_wp(i_wp),
        .i_chip_select_straps(3'h5), .o_standby(standby));
    eesl_ctrl_model u_eesl_ctrl_model (.i_clk(i_clk), .i_sda(sda), .o_scl(scl),
        .o_sda_low(low));
    ////////////////////////////////////////////////////////////////////////////
    // Bus helpers.
    task automatic st(); u_eesl_ctrl_model.start(); endtask
    task automatic sp(); u_eesl_ctrl_model.stop(); endtask
    task automatic wb(input logic [7:0] b, input logic e);
        logic a;
        u_eesl_ctrl_model.wbyte(b, a);
        `CHK("ack", e, a)
    endtask
    task automatic rb(input logic nack, input logic [7:0] e);
        logic [7:0] d;
        u_eesl_ctrl_model.rbyte(nack, d);
        `CHK("data", e, d)
    endtask
    task automatic seek(input logic [15:0] a);
        st();
        wb(DW, 1'h1);
        wb(a[15:8], 1'h1);
        wb(a[7:0], 1'h1);
    endtask
    // Bounded wait for standby; running out ends the run.
    task automatic idle();
        int i;
        for (i = 0; i < 400 && standby !== 1'h1; i++) @(negedge i_clk);
        if (i == 400) begin
            `CHK("idle", 1'h1, standby)
            conclude();
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic t_byte();  // Top address bit set, so the byte lands at 0x0000.
        seek(16'h8000);
        wb(8'h5a, 1'h1);
        sp();
        u_eesl_ctrl_model.hold(2);
        `CHK("busy", 1'h0, standby)
        st();
        wb(DW, 1'h0);
        sp();
        idle();
        seek(16'h0000);
        st();
        wb(DR, 1'h1);
        rb(1'h1, 8'h5a);
        sp();
        $display("done t_byte");
    endtask
    task automatic t_wp();
        i_wp = 1'h1;
        seek(16'h0000);
        wb(8'hee, 1'h1);
        sp();
        u_eesl_ctrl_model.hold(4);
        `CHK("wp idle", 1'h1, standby)
        i_wp = 1'h0;
        seek(16'h0000);
        st();
        wb(DR, 1'h1);
        rb(1'h1, 8'h5a);
        sp();
        $display("done t_wp");
    endtask
    task automatic t_page();  // 65 bytes: the last one wraps onto column 0.
        seek(16'h0040);
        for (int i = 0; i < 65; i++) wb(8'(i), 1'h1);
        sp();
        idle();
        seek(16'h0040);
        st();
        wb(DR, 1'h1);
        rb(1'h0, 8'h40);
        rb(1'h0, 8'h01);
        rb(1'h1, 8'h02);
        sp();
        st();
        wb(DR, 1'h1);
        rb(1'h1, 8'h03);
        sp();
        $display("done t_page");
    endtask
    task automatic t_wrap();  // Reads roll from the array end to 0x0000.
        seek(16'h7fff);
        wb(8'hc3, 1'h1);
        sp();
        idle();
        seek(16'h7fff);
        st();
        wb(DR, 1'h1);
        rb(1'h0, 8'hc3);
        rb(1'h1, 8'h5a);
        sp();
        $display("done t_wrap");
    endtask
    task automatic t_refuse();
        logic a;
        st();
        wb(8'ha0, 1'h0);
        sp();
        st();
        wb(8'hba, 1'h0);
        sp();
        `CHK("standby", 1'h1, standby)
        seek(16'h0000);
        st();
        u_eesl_ctrl_model.wbyte(8'hff, a);
        st();
        sp();
        st();
        wb(DW, 1'h1);
        sp();
        $display("done t_refuse");
    endtask
    // Clock of 100 ns.
    initial begin
        i_clk = 1'h0;
        forever #50 i_clk = !i_clk;
    end
    // Main sequence.
    initial begin
        n_errors = 0;
        comparisons = 0;
        i_wp = 1'h0;
        i_reset_n = 1'h0;
        repeat (4) @(negedge i_clk);
        i_reset_n = 1'h1;
        u_eesl_ctrl_model.hold(3);
        t_byte();
        t_wp();
        t_page();
        t_wrap();
        t_refuse();
        conclude();
    end
endmodule
bind eesl_slave eesl_monitor #(.PROG_CYCLES(PROG_CYCLES)) u_eesl_monitor (.i_clk(i_clk),
    .i_reset_n(i_reset_n), .i_scl(i_scl), .i_sda(i_sda), .o_sda_out(o_sda_out),
    .o_sda_oe(o_sda_oe), .i_wp(i_wp), .i_chip_select_straps(i_chip_select_straps),
    .o_standby(o_standby));
